// File: hw/sfr_regs.svh
`ifndef SFR_REGS_SVH
`define SFR_REGS_SVH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define SFR_OP_READ 8'h03
`define SFR_OP_FAST 8'h0b
`define SFR_OP_DUAL_OUT 8'h3b
`define SFR_OP_DUAL_IO 8'hbb
`define SFR_OP_QUAD_OUT 8'h6b
`define SFR_OP_QUAD_IO 8'heb
`define SFR_OP_EXIT 8'hff

// ----------------------------------------
// Frame layout, in serial clocks
// ----------------------------------------
`define SFR_ADDR_W 24
`define SFR_ARRAY_TOP 24'h1fffff
`define SFR_OP_CLKS 8
`define SFR_DUM_FAST 8
`define SFR_DUM_DUAL_OUT 8
`define SFR_DUM_DUAL_IO 4
`define SFR_DUM_QUAD_OUT 8
`define SFR_IND_QUAD_IO 2
`define SFR_DUM_QUAD_IO 4
`define SFR_HOLD_CLKS 2

// ----------------------------------------
// Timing
// ----------------------------------------
`define SFR_CLK_NS 8
`define SFR_SCLK_NS 64

`endif

// File: hw/sfr_pkg.sv
package sfr_pkg;

`include "sfr_regs.svh"

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    SFR_READ = 3'b000,
    SFR_FAST = 3'b001,
    SFR_DUAL_OUT = 3'b010,
    SFR_DUAL_IO = 3'b011,
    SFR_QUAD_OUT = 3'b100,
    SFR_QUAD_IO = 3'b101
  } sfr_cmd_t;

  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_CMD = 3'b001,
    D_ADDR = 3'b010,
    D_IND = 3'b011,
    D_DUM = 3'b100,
    D_DATA = 3'b101,
    D_REJ = 3'b110
  } sfr_dst_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_LOW = 2'b01,
    H_HIGH = 2'b10,
    H_TAIL = 2'b11
  } sfr_hst_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [2:0] adr_lanes;
    logic [4:0] adr_clks;
    logic [1:0] ind_clks;
    logic [3:0] dum_clks;
    logic [2:0] dat_lanes;
    logic gated;
    logic quad;
  } sfr_cfg_t;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic sfr_cfg_t sfr_cfg(input sfr_cmd_t c);
    sfr_cfg_t f;
    f = '0;
    f.adr_lanes = 3'd1;
    f.dat_lanes = 3'd1;
    f.gated = 1'b1;
    unique case (c)
      SFR_READ: begin
        f.opcode = `SFR_OP_READ;
        f.gated = 1'b0;
      end
      SFR_FAST: begin
        f.opcode = `SFR_OP_FAST;
        f.dum_clks = 4'(`SFR_DUM_FAST);
      end
      SFR_DUAL_OUT: begin
        f.opcode = `SFR_OP_DUAL_OUT;
        f.dum_clks = 4'(`SFR_DUM_DUAL_OUT);
        f.dat_lanes = 3'd2;
      end
      SFR_DUAL_IO: begin
        f.opcode = `SFR_OP_DUAL_IO;
        f.adr_lanes = 3'd2;
        f.dum_clks = 4'(`SFR_DUM_DUAL_IO);
        f.dat_lanes = 3'd2;
      end
      SFR_QUAD_OUT: begin
        f.opcode = `SFR_OP_QUAD_OUT;
        f.dum_clks = 4'(`SFR_DUM_QUAD_OUT);
        f.dat_lanes = 3'd4;
        f.quad = 1'b1;
      end
      default: begin
        f.opcode = `SFR_OP_QUAD_IO;
        f.adr_lanes = 3'd4;
        f.ind_clks = 2'(`SFR_IND_QUAD_IO);
        f.dum_clks = 4'(`SFR_DUM_QUAD_IO);
        f.dat_lanes = 3'd4;
        f.quad = 1'b1;
      end
    endcase
    f.adr_clks = 5'(`SFR_ADDR_W / int'(f.adr_lanes));
    return f;
  endfunction

  // Returns {valid, command}
  function automatic logic [3:0] sfr_decode(input logic [7:0] op);
    case (op)
      `SFR_OP_READ: return {1'b1, SFR_READ};
      `SFR_OP_FAST: return {1'b1, SFR_FAST};
      `SFR_OP_DUAL_OUT: return {1'b1, SFR_DUAL_OUT};
      `SFR_OP_DUAL_IO: return {1'b1, SFR_DUAL_IO};
      `SFR_OP_QUAD_OUT: return {1'b1, SFR_QUAD_OUT};
      `SFR_OP_QUAD_IO: return {1'b1, SFR_QUAD_IO};
      default: return 4'h0;
    endcase
  endfunction

  // Shift a lane group in at the bottom, top lane is the most significant bit
  function automatic logic [31:0] sfr_shl(input logic [31:0] v, input logic [2:0] lanes, input logic [3:0] b);
    case (lanes)
      3'd4: return {v[27:0], b};
      3'd2: return {v[29:0], b[1:0]};
      default: return {v[30:0], b[0]};
    endcase
  endfunction

  // Collect the lanes of a group; a single line reads lane 1 when so is set
  function automatic logic [3:0] sfr_pick(input logic [2:0] lanes, input logic [3:0] io, input logic so);
    case (lanes)
      3'd4: return io;
      3'd2: return {2'b00, io[1:0]};
      default: return {3'b000, so ? io[1] : io[0]};
    endcase
  endfunction

  // Active low enables for the host driving the low lanes
  function automatic logic [3:0] sfr_oe(input logic [2:0] lanes);
    case (lanes)
      3'd4: return 4'h0;
      3'd2: return 4'hc;
      default: return 4'he;
    endcase
  endfunction

  function automatic logic [2:0] sfr_glast(input logic [2:0] lanes);
    case (lanes)
      3'd4: return 3'd1;
      3'd2: return 3'd3;
      default: return 3'd7;
    endcase
  endfunction

endpackage

// File: hw/sfr_if.sv
`timescale 1ns/100ps
interface sfr_if;
  logic cs_n;
  logic sclk;
  logic [3:0] host_out;
  logic [3:0] host_oe_n;
  logic [3:0] dev_out;
  logic [3:0] dev_oe_n;
  logic [3:0] io;

  // Wired lanes with pull-up: an undriven lane reads high
  assign io = (host_out | host_oe_n) & (dev_out | dev_oe_n);

  modport host (
    output cs_n,
    output sclk,
    output host_out,
    output host_oe_n,
    input io
  );

  modport dev (
    input cs_n,
    input sclk,
    input io,
    output dev_out,
    output dev_oe_n
  );
endinterface

// File: hw/sfr_sync.sv
`timescale 1ns/100ps
module sfr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  generate
    if (W < 1) begin : g_chk
      $error("sfr_sync width must be at least one");
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!nrst) begin
      // Reset to the idle level of each pin so no false edge follows reset
      meta_r <= INIT;
      q <= INIT;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// File: hw/sfr_dev.sv
// Behaviour
// - Sample on clock rise, drive on fall.
// - Any start, increment per byte, wrap zero.
// - Plain read: opcode, address, stream until deselect.
// - Dummy-byte read adds one dummy byte.
// - Busy rejects dummy, dual, quad reads sent with an opcode.
// - Dual output: eight dummy clocks, two lanes.
// - Dual I/O: address, four dummies, two lanes.
// - Opcode BB decodes as dual I/O.
// - Host holds a lane steady early dummies.
// - Host enables quad lanes before quad.
// - Opcode 6B: quad output, eight dummies.
// - Quad I/O: address, indicator, dummies, four lanes.
// - Complementary indicator skips next opcode.
// - Stay opcode-less while indicator stays complementary.
// - Other indicator leaves after next deselect.
// - Host keeps slow quad reads within bank.
// - Exit command leaves opcode-less mode.
// - Opcode-less mode only in high performance.
`timescale 1ns/100ps
`include "sfr_regs.svh"
module sfr_dev
  import sfr_pkg::*;
#(
  parameter int DEPTH = 256,
  parameter logic [23:0] ARRAY_TOP = `SFR_ARRAY_TOP
) (
  input wire logic clock,
  input wire logic nrst,
  sfr_if.dev link,
  input wire logic wip,
  input wire logic quad_lanes_enable,
  input wire logic high_perf,
  input wire logic load_en,
  input wire logic [$clog2(DEPTH)-1:0] load_addr,
  input wire logic [7:0] load_data,
  output logic cont_mode,
  output logic [23:0] cur_addr
);
  localparam int IW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || (DEPTH - 1) > int'(ARRAY_TOP)) begin : g_chk
      $error("sfr_dev DEPTH must be a power of two within the array");
    end
  endgenerate

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    sfr_dst_t st;
    logic sclk_d;
    logic [7:0] op;
    sfr_cfg_t cfg;
    logic [4:0] cnt;
    logic [23:0] addr;
    logic [7:0] ind;
    logic cont;
    logic [7:0] sr;
    logic [2:0] grp;
    logic [3:0] io_out;
    logic [3:0] io_oe_n;
    logic [DEPTH-1:0][7:0] mem;
  } sfr_dev_state_t;

  sfr_dev_state_t q_r;
  sfr_dev_state_t q_nxt;
  logic [5:0] syn;
  logic sclk_s;
  logic cs_n_s;
  logic [3:0] io_s;
  logic rise;
  logic fall;

  // ----------------------------------------
  // Link input synchroniser
  // ----------------------------------------
  sfr_sync #(
    .W(6),
    .INIT(6'b111110)
  ) u_sync (
    .clock(clock),
    .nrst(nrst),
    .d({link.io, link.cs_n, link.sclk}),
    .q(syn)
  );

  assign {io_s, cs_n_s, sclk_s} = syn;
  assign rise = sclk_s & ~q_r.sclk_d;
  assign fall = ~sclk_s & q_r.sclk_d;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    logic [3:0] din;
    logic [7:0] opv;
    logic [3:0] dec;
    logic [23:0] av;
    logic [7:0] iv;
    logic [7:0] bv;
    din = sfr_pick(q_r.cfg.adr_lanes, io_s, 1'b0);
    opv = {q_r.op[6:0], io_s[0]};
    dec = sfr_decode(opv);
    av = 24'(sfr_shl({8'h00, q_r.addr}, q_r.cfg.adr_lanes, din));
    iv = {q_r.ind[3:0], io_s};
    bv = (q_r.grp == 3'd0) ? q_r.mem[q_r.addr[IW-1:0]] : q_r.sr;
    q_nxt = q_r;
    q_nxt.sclk_d = sclk_s;
    if (load_en) begin
      q_nxt.mem[load_addr] = load_data;
    end
    if (!high_perf) begin
      q_nxt.cont = 1'b0;
    end
    if (cs_n_s) begin
      q_nxt.st = D_IDLE;
      q_nxt.io_oe_n = 4'hf;
      q_nxt.cnt = '0;
      q_nxt.grp = '0;
    end else begin
      unique case (q_r.st)
        D_IDLE: begin
          q_nxt.cnt = '0;
          if (q_r.cont && high_perf) begin
            q_nxt.cfg = sfr_cfg(SFR_QUAD_IO);
            q_nxt.st = D_ADDR;
          end else begin
            q_nxt.st = D_CMD;
          end
        end
        D_CMD: begin
          if (rise) begin
            q_nxt.op = opv;
            q_nxt.cnt = q_r.cnt + 5'd1;
            if (q_r.cnt == 5'(`SFR_OP_CLKS - 1)) begin
              q_nxt.cnt = '0;
              q_nxt.cfg = sfr_cfg(sfr_cmd_t'(dec[2:0]));
              if (opv == `SFR_OP_EXIT) begin
                q_nxt.cont = 1'b0;
                q_nxt.st = D_REJ;
              end else if (!dec[3]) begin
                q_nxt.st = D_REJ;
              end else if ((q_nxt.cfg.gated && wip) || (q_nxt.cfg.quad && !quad_lanes_enable)) begin
                q_nxt.st = D_REJ;
              end else begin
                q_nxt.st = D_ADDR;
              end
            end
          end
        end
        D_ADDR: begin
          if (rise) begin
            q_nxt.addr = av;
            q_nxt.cnt = q_r.cnt + 5'd1;
            if (q_r.cont && q_r.cnt == 5'd1 && av[7:0] == `SFR_OP_EXIT) begin
              q_nxt.cont = 1'b0;
              q_nxt.st = D_REJ;
            end else if (q_r.cnt == q_r.cfg.adr_clks - 5'd1) begin
              q_nxt.cnt = '0;
              if (q_r.cfg.ind_clks != 2'd0) begin
                q_nxt.st = D_IND;
              end else if (q_r.cfg.dum_clks != 4'd0) begin
                q_nxt.st = D_DUM;
              end else begin
                q_nxt.st = D_DATA;
              end
            end
          end
        end
        D_IND: begin
          if (rise) begin
            q_nxt.ind = iv;
            q_nxt.cnt = q_r.cnt + 5'd1;
            if (q_r.cnt == 5'(q_r.cfg.ind_clks) - 5'd1) begin
              q_nxt.cnt = '0;
              q_nxt.cont = high_perf && (iv[7:4] == ~iv[3:0]);
              q_nxt.st = D_DUM;
            end
          end
        end
        D_DUM: begin
          if (rise) begin
            q_nxt.cnt = q_r.cnt + 5'd1;
            if (q_r.cnt == 5'(q_r.cfg.dum_clks) - 5'd1) begin
              q_nxt.cnt = '0;
              q_nxt.st = D_DATA;
            end
          end
        end
        D_DATA: begin
          if (fall) begin
            unique case (q_r.cfg.dat_lanes)
              3'd4: begin
                q_nxt.io_out = bv[7:4];
                q_nxt.io_oe_n = 4'h0;
              end
              3'd2: begin
                q_nxt.io_out = {2'b00, bv[7:6]};
                q_nxt.io_oe_n = 4'hc;
              end
              default: begin
                q_nxt.io_out = {2'b00, bv[7], 1'b0};
                q_nxt.io_oe_n = 4'hd;
              end
            endcase
            q_nxt.sr = 8'(sfr_shl({24'h000000, bv}, q_r.cfg.dat_lanes, 4'h0));
            if (q_r.grp == sfr_glast(q_r.cfg.dat_lanes)) begin
              q_nxt.grp = '0;
            end else begin
              q_nxt.grp = q_r.grp + 3'd1;
            end
            if (q_r.grp == 3'd0) begin
              q_nxt.addr = (q_r.addr >= ARRAY_TOP) ? 24'h000000 : q_r.addr + 24'h000001;
            end
          end
        end
        D_REJ: begin
          q_nxt.io_oe_n = 4'hf;
        end
        default: begin
          q_nxt.st = D_REJ;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      q_r <= '0;
      q_r.io_oe_n <= 4'hf;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign link.dev_out = q_r.io_out;
  assign link.dev_oe_n = q_r.io_oe_n;
  assign cont_mode = q_r.cont;
  assign cur_addr = q_r.addr;
endmodule

// File: hw/sfr_host.sv
`timescale 1ns/100ps
`include "sfr_regs.svh"
module sfr_host
  import sfr_pkg::*;
#(
  parameter int HALF = `SFR_SCLK_NS / (2 * `SFR_CLK_NS)
) (
  input wire logic clock,
  input wire logic nrst,
  sfr_if.host link,
  input wire logic start,
  input wire sfr_cmd_t sel,
  input wire logic skip_op,
  input wire logic [23:0] addr,
  input wire logic [7:0] ind,
  input wire logic [15:0] nbytes,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic done,
  output logic busy
);
  localparam logic [7:0] HLAST = 8'(HALF - 1);

  generate
    if (HALF < 4 || HALF > 256) begin : g_chk
      $error("sfr_host HALF must be 4 to 256 clocks");
    end
  endgenerate

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    sfr_hst_t st;
    logic [7:0] div;
    logic [7:0] clk;
    sfr_cfg_t cfg;
    logic [7:0] opc;
    logic [7:0] pre;
    logic [7:0] op_sr;
    logic [31:0] tx;
    logic [7:0] rx;
    logic [2:0] grp;
    logic [15:0] left;
    logic cs_n;
    logic sclk;
    logic [3:0] io_out;
    logic [3:0] io_oe_n;
    logic [7:0] rd_data;
    logic rd_valid;
    logic done;
    logic busy;
  } sfr_host_state_t;

  sfr_host_state_t q_r;
  sfr_host_state_t q_nxt;
  logic [3:0] io_s;

  sfr_sync #(
    .W(4)
  ) u_sync (
    .clock(clock),
    .nrst(nrst),
    .d(link.io),
    .q(io_s)
  );

  // ----------------------------------------
  // Frame generator
  // ----------------------------------------
  always_comb begin
    logic [7:0] ka;
    logic [7:0] rxv;
    logic bdone;
    ka = q_r.opc + 8'(q_r.cfg.adr_clks) + 8'(q_r.cfg.ind_clks);
    rxv = 8'(sfr_shl({24'h000000, q_r.rx}, q_r.cfg.dat_lanes, sfr_pick(q_r.cfg.dat_lanes, io_s, 1'b1)));
    bdone = (q_r.grp == sfr_glast(q_r.cfg.dat_lanes));
    q_nxt = q_r;
    q_nxt.rd_valid = 1'b0;
    q_nxt.done = 1'b0;
    unique case (q_r.st)
      H_IDLE: begin
        if (start) begin
          q_nxt.cfg = sfr_cfg(sel);
          q_nxt.opc = (skip_op && sel == SFR_QUAD_IO) ? 8'h00 : 8'(`SFR_OP_CLKS);
          q_nxt.pre = q_nxt.opc + 8'(q_nxt.cfg.adr_clks) + 8'(q_nxt.cfg.ind_clks) + 8'(q_nxt.cfg.dum_clks);
          q_nxt.op_sr = q_nxt.cfg.opcode;
          q_nxt.tx = {addr, ind};
          q_nxt.left = nbytes;
          q_nxt.clk = '0;
          q_nxt.div = '0;
          q_nxt.grp = '0;
          q_nxt.cs_n = 1'b0;
          q_nxt.busy = 1'b1;
          q_nxt.st = H_LOW;
        end
      end
      H_LOW: begin
        q_nxt.div = q_r.div + 8'd1;
        if (q_r.div == 8'd0) begin
          if (q_r.clk < q_r.opc) begin
            q_nxt.io_out = {3'b000, q_r.op_sr[7]};
            q_nxt.op_sr = {q_r.op_sr[6:0], 1'b0};
            q_nxt.io_oe_n = 4'he;
          end else if (q_r.clk < ka) begin
            q_nxt.io_out = q_r.tx[31:28] >> (3'd4 - q_r.cfg.adr_lanes);
            q_nxt.tx = sfr_shl(q_r.tx, q_r.cfg.adr_lanes, 4'h0);
            q_nxt.io_oe_n = sfr_oe(q_r.cfg.adr_lanes);
          end else if (q_r.clk < ka + 8'(`SFR_HOLD_CLKS)) begin
            q_nxt.io_out = 4'h0;
          end else begin
            q_nxt.io_oe_n = 4'hf;
          end
        end
        if (q_r.div == HLAST) begin
          q_nxt.div = '0;
          q_nxt.sclk = 1'b1;
          q_nxt.clk = q_r.clk + 8'd1;
          q_nxt.st = H_HIGH;
        end
      end
      H_HIGH: begin
        q_nxt.div = q_r.div + 8'd1;
        if (q_r.div == HLAST) begin
          q_nxt.div = '0;
          q_nxt.sclk = 1'b0;
          q_nxt.st = H_LOW;
          if (q_r.clk > q_r.pre && q_r.left != 16'd0) begin
            q_nxt.rx = rxv;
            q_nxt.grp = bdone ? 3'd0 : q_r.grp + 3'd1;
            if (bdone) begin
              q_nxt.rd_data = rxv;
              q_nxt.rd_valid = 1'b1;
              q_nxt.left = q_r.left - 16'd1;
            end
          end
          if (q_r.clk >= q_r.pre && q_nxt.left == 16'd0) begin
            q_nxt.io_oe_n = 4'hf;
            q_nxt.st = H_TAIL;
          end
        end
      end
      H_TAIL: begin
        q_nxt.div = q_r.div + 8'd1;
        if (q_r.div == HLAST) begin
          q_nxt.div = '0;
          if (q_r.cs_n) begin
            q_nxt.busy = 1'b0;
            q_nxt.done = 1'b1;
            q_nxt.st = H_IDLE;
          end else begin
            q_nxt.cs_n = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      q_r <= '0;
      q_r.cs_n <= 1'b1;
      q_r.io_oe_n <= 4'hf;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign link.cs_n = q_r.cs_n;
  assign link.sclk = q_r.sclk;
  assign link.host_out = q_r.io_out;
  assign link.host_oe_n = q_r.io_oe_n;
  assign rd_data = q_r.rd_data;
  assign rd_valid = q_r.rd_valid;
  assign done = q_r.done;
  assign busy = q_r.busy;
endmodule

// File: tb/sfr_chk.sv
`timescale 1ns/100ps
module sfr_chk (
  input wire logic clock,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] host_out,
  input wire logic [3:0] host_oe_n,
  input wire logic [3:0] dev_out,
  input wire logic [3:0] dev_oe_n,
  input wire logic [3:0] io
);
  logic sclk_r;
  logic op_mode_r;
  logic [7:0] rise_cnt_r;
  logic [7:0] op_r;
  logic [1:0] io_prev_r;
  logic rise;
  logic op_ok;

  assign rise = sclk & ~sclk_r;
  assign op_ok = op_mode_r & (rise_cnt_r >= 8'h08);

  // ----------------------------------------
  // Frame tracking
  // ----------------------------------------
  always_ff @(posedge clock) begin
    sclk_r <= nrst & sclk;
    if (!nrst || cs_n) begin
      rise_cnt_r <= 8'h00;
      op_mode_r <= 1'b0;
      op_r <= 8'h00;
      io_prev_r <= 2'b00;
    end else if (rise) begin
      rise_cnt_r <= rise_cnt_r + 8'(rise_cnt_r != 8'hff);
      io_prev_r <= io[1:0];
      if (rise_cnt_r == 8'h00) begin
        op_mode_r <= (host_oe_n == 4'he);
      end
      if (rise_cnt_r < 8'h08) begin
        op_r <= {op_r[6:0], io[0]};
      end
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_high_phase;
    sclk [*4] ##1 !sclk;
  endsequence

  property p_lanes(logic [7:0] op, int pre, logic [3:0] oe);
    !cs_n && op_ok && op_r == op |-> dev_oe_n == 4'hf || (rise_cnt_r >= pre && dev_oe_n == oe);
  endproperty

  chk_dev_release: assert property (cs_n [*6] |-> dev_oe_n == 4'hf)
    else $error("device drives while deselected");
  chk_drive_on_fall: assert property (((~dev_oe_n) & ~$past(dev_oe_n) & (dev_out ^ $past(dev_out))) != 4'h0
    |-> !$past(sclk, 2) && !$past(sclk, 3))
    else $error("device data changed outside the low phase");
  chk_no_contention: assert property ((~host_oe_n & ~dev_oe_n) == 4'h0)
    else $error("both ends drive one lane");
  chk_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("serial clock high while deselected");
  chk_sclk_half: assert property ($rose(sclk) |-> s_high_phase)
    else $error("serial clock high phase wrong");
  chk_dual_hold: assert property (rise && op_ok && op_r == 8'hbb && rise_cnt_r == 8'd21
    |-> io[0] == io_prev_r[0] || io[1] == io_prev_r[1])
    else $error("both low lanes toggled in early dummies");
  chk_read_lanes: assert property (p_lanes(8'h03, 32, 4'hd))
    else $error("plain read lanes wrong");
  chk_fast_lanes: assert property (p_lanes(8'h0b, 40, 4'hd))
    else $error("dummy byte read lanes wrong");
  chk_dual_out_lanes: assert property (p_lanes(8'h3b, 40, 4'hc))
    else $error("dual output lanes wrong");
  chk_dual_io_lanes: assert property (p_lanes(8'hbb, 24, 4'hc))
    else $error("dual io lanes wrong");
  chk_quad_out_lanes: assert property (p_lanes(8'h6b, 40, 4'h0))
    else $error("quad output lanes wrong");
  chk_quad_io_lanes: assert property (p_lanes(8'heb, 20, 4'h0))
    else $error("quad io lanes wrong");
endmodule

// File: tb/test_serial_flash_multi_io_read.sv
`timescale 1ns/100ps
module test_serial_flash_multi_io_read;
  import sfr_pkg::*;

  localparam logic [23:0] TOP = 24'h00017f;
  localparam logic [7:0] OPS [6] = '{8'h03, 8'h0b, 8'h3b, 8'hbb, 8'h6b, 8'heb};
  localparam logic [7:0] STAY [4] = '{8'h5a, 8'hf0, 8'h0f, 8'ha5};
  localparam logic [7:0] QUIT [4] = '{8'hff, 8'h00, 8'haa, 8'h55};

  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic start = 1'b0;
  sfr_cmd_t sel = SFR_READ;
  logic skip_op = 1'b0;
  logic [23:0] addr = 24'h000000;
  logic [7:0] ind = 8'h00;
  logic [15:0] nbytes = 16'h0000;
  logic wip = 1'b0;
  logic quad_lanes_enable = 1'b1;
  logic high_perf = 1'b1;
  logic load_en = 1'b0;
  logic [7:0] load_addr = 8'h00;
  logic [7:0] load_data = 8'h00;
  logic [7:0] rd_data;
  logic rd_valid;
  logic done;
  logic busy;
  logic cont_mode;
  logic [23:0] cur_addr;
  logic [7:0] mem [256];
  logic [7:0] wire_op;
  logic [31:0] r;
  int rises = 0;
  int n_fail = 0;
  int cmp_count = 0;

  always #4 clock = ~clock;

  sfr_if u_sfr_if();

  sfr_host #(.HALF(4)) u_sfr_host (.clock(clock), .nrst(nrst), .link(u_sfr_if.host), .start(start), .sel(sel),
    .skip_op(skip_op), .addr(addr), .ind(ind), .nbytes(nbytes), .rd_data(rd_data), .rd_valid(rd_valid),
    .done(done), .busy(busy));

  sfr_dev #(.DEPTH(256), .ARRAY_TOP(TOP)) u_sfr_dev (.clock(clock), .nrst(nrst), .link(u_sfr_if.dev),
    .wip(wip), .quad_lanes_enable(quad_lanes_enable), .high_perf(high_perf), .load_en(load_en),
    .load_addr(load_addr), .load_data(load_data), .cont_mode(cont_mode), .cur_addr(cur_addr));

  sfr_chk u_sfr_chk (.clock(clock), .nrst(nrst), .cs_n(u_sfr_if.cs_n), .sclk(u_sfr_if.sclk),
    .host_out(u_sfr_if.host_out), .host_oe_n(u_sfr_if.host_oe_n), .dev_out(u_sfr_if.dev_out),
    .dev_oe_n(u_sfr_if.dev_oe_n), .io(u_sfr_if.io));

  // ----------------------------------------
  // Wire monitor: first byte on lane 0
  // ----------------------------------------
  always @(posedge u_sfr_if.sclk) begin
    if (rises < 8) begin
      wire_op = {wire_op[6:0], u_sfr_if.io[0]};
    end
    rises++;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic logic [23:0] next_addr(input logic [23:0] a);
    return (a >= TOP) ? 24'h000000 : a + 24'h000001;
  endfunction

  task automatic conclude();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic xfer(input sfr_cmd_t c, input logic sk, input logic [23:0] a, input logic [7:0] p,
      input int n, input logic good, input logic ec);
    int k;
    int t;
    logic [23:0] ea;
    k = 0;
    t = 0;
    ea = a;
    @(posedge clock);
    #1;
    sel = c;
    skip_op = sk;
    addr = a;
    ind = p;
    nbytes = 16'(n);
    start = 1'b1;
    rises = 0;
    @(posedge clock);
    #1;
    start = 1'b0;
    check("busy", 24'h000001, {23'h0, busy});
    while (done !== 1'b1 && t < 3000) begin
      if (rd_valid === 1'b1) begin
        check("rd_data", {16'h0, good ? mem[ea[7:0]] : 8'hff}, {16'h0, rd_data});
        ea = next_addr(ea);
        k++;
      end
      @(posedge clock);
      #1;
      t++;
    end
    check("done", 24'h000001, {23'h0, done});
    check("busy", 24'h000000, {23'h0, busy});
    // The byte begun at the closing fall is loaded too, so one step more
    if (good) begin
      check("cur_addr", next_addr(ea), cur_addr);
    end
    check("bytes", 24'(n), 24'(k));
    check("cont_mode", {23'h0, ec}, {23'h0, cont_mode});
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (80000) @(posedge clock);
    n_fail++;
    conclude();
  end

  initial begin
    void'($urandom(32'h2fd9));
    repeat (5) @(posedge clock);
    #1;
    nrst = 1'b1;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'($urandom);
      load_en = 1'b1;
      load_addr = 8'(i);
      load_data = mem[i];
      @(posedge clock);
      #1;
    end
    load_en = 1'b0;
    for (int c = 0; c < 6; c++) begin
      xfer(sfr_cmd_t'(c), 1'b0, 24'($urandom), 8'hff, 3, 1'b1, 1'b0);
      check("opcode", {16'h0, OPS[c]}, {16'h0, wire_op});
    end
    xfer(SFR_READ, 1'b0, TOP - 24'h000001, 8'h00, 4, 1'b1, 1'b0);
    xfer(SFR_FAST, 1'b0, TOP, 8'h00, 0, 1'b1, 1'b0);
    wip = 1'b1;
    for (int c = 0; c < 6; c++) begin
      xfer(sfr_cmd_t'(c), 1'b0, 24'h000010, 8'h00, 2, c == 0, 1'b0);
    end
    wip = 1'b0;
    quad_lanes_enable = 1'b0;
    xfer(SFR_QUAD_OUT, 1'b0, 24'h000020, 8'h00, 2, 1'b0, 1'b0);
    xfer(SFR_QUAD_IO, 1'b0, 24'h000020, 8'ha5, 2, 1'b0, 1'b0);
    quad_lanes_enable = 1'b1;
    xfer(SFR_QUAD_IO, 1'b0, 24'h000130, 8'ha5, 3, 1'b1, 1'b1);
    foreach (STAY[i]) begin
      xfer(SFR_QUAD_IO, 1'b1, {8'h00, 16'($urandom)}, STAY[i], 2, 1'b1, 1'b1);
    end
    foreach (QUIT[i]) begin
      xfer(SFR_QUAD_IO, 1'b1, {8'h00, 16'($urandom)}, QUIT[i], 2, 1'b1, 1'b0);
      xfer(SFR_QUAD_IO, 1'b0, 24'($urandom), 8'h5a, 1, 1'b1, 1'b1);
    end
    xfer(SFR_QUAD_IO, 1'b1, 24'hff0000, 8'hff, 1, 1'b0, 1'b0);
    xfer(SFR_QUAD_IO, 1'b0, 24'h000040, 8'hf0, 1, 1'b1, 1'b1);
    high_perf = 1'b0;
    xfer(SFR_QUAD_IO, 1'b0, 24'h000050, 8'h0f, 1, 1'b1, 1'b0);
    high_perf = 1'b1;
    repeat (10) begin
      r = $urandom;
      xfer(sfr_cmd_t'(r % 6), 1'b0, 24'($urandom), {r[11:8], r[11:8]}, int'(r[15:12] % 5), 1'b1, 1'b0);
    end
    conclude();
  end
endmodule
